// file: logic/smch_pkg.sv
// constants shared by the serial command handler and its helper modules
package smch_pkg;
    // function codes
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FC_SAVE = 8'h41;
    localparam logic [7:0] FC_SERVO = 8'h42;
    localparam logic [7:0] FC_ALARM_CLR = 8'h43;
    localparam logic [7:0] FC_JOG = 8'h44;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    // exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
    localparam logic [7:0] EXC_BAD_INDEX = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [7:0] EXC_BUSY = 8'h04;
    // command arguments
    localparam logic [7:0] SERVO_ON = 8'h55;
    localparam logic [7:0] SERVO_OFF = 8'hAA;
    localparam logic [7:0] JOG_EXIT = 8'h00;
    localparam logic [7:0] JOG_FWD = 8'h01;
    localparam logic [7:0] JOG_REV = 8'h02;
    localparam logic [7:0] JOG_HOLD = 8'h03;
    localparam logic [15:0] SAVE_KEY_INDEX = 16'h1001;
    localparam logic [15:0] SAVE_KEY_VALUE = 16'h1234;
    localparam logic [15:0] JOG_SPEED_INDEX = 16'h004C;
    localparam logic [15:0] JOG_SPEED_RESET = 16'h0000;
    localparam logic [16:0] PARAM_COUNT = 17'h0_0100;
    localparam logic [15:0] MAX_WRITE_COUNT = 16'h000A;
    // frame layout: byte positions
    localparam logic [4:0] POS_ADDR = 5'h00;
    localparam logic [4:0] POS_FC = 5'h01;
    localparam logic [4:0] POS_ARG = 5'h02;
    localparam logic [4:0] POS_IDX_L = 5'h03;
    localparam logic [4:0] POS_CNT_H = 5'h04;
    localparam logic [4:0] POS_CNT_L = 5'h05;
    localparam logic [4:0] POS_BYTES = 5'h06;
    localparam logic [4:0] POS_DATA = 5'h07;
    // frame lengths; requests include the check code, the multi-write and exception replies exclude it
    localparam logic [5:0] LEN_MIN = 6'h04;
    localparam logic [5:0] LEN_BARE = 6'h04;
    localparam logic [5:0] LEN_ONE_ARG = 6'h05;
    localparam logic [5:0] LEN_DIAG = 6'h06;
    localparam logic [5:0] LEN_WRITE_ONE = 6'h08;
    localparam logic [6:0] LEN_MULTI_FIXED = 7'h09;
    localparam logic [5:0] LEN_MULTI_REPLY = 6'h06;
    localparam logic [5:0] LEN_EXC_REPLY = 6'h03;
    // frame store
    localparam int BUF_DEPTH = 32;
    localparam logic [5:0] BUF_FULL = 6'h20;
    // check code
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CHECK = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_EXC_FC = 4'b0011,
        ST_EXC_CODE = 4'b0100,
        ST_TX = 4'b0101,
        ST_TX_CRC_LO = 4'b0110,
        ST_TX_CRC_HI = 4'b0111,
        ST_DRAIN = 4'b1000
    } smch_state_e;
endpackage

// file: logic/smch_crc16.sv
// bytewise check-code accumulator, one byte per clock
`timescale 1ns/10ps
`default_nettype none
module smch_crc16 (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic [15:0] crc
);
    logic [15:0] stage [9];
    logic [15:0] crc_reg;

    assign stage[0] = crc_reg ^ {8'h00, byte_data};
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_bit
            assign stage[g + 1] = stage[g][0] ? ((stage[g] >> 1) ^ smch_pkg::CRC_POLY)
                                              : (stage[g] >> 1);
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst || clear) begin
            crc_reg <= smch_pkg::CRC_INIT;
        end else if (byte_valid) begin
            crc_reg <= stage[8];
        end
    end

    assign crc = crc_reg;
endmodule
`default_nettype wire

// file: logic/smch_frame_store.sv
// byte store for one frame, single write port, all entries visible
`timescale 1ns/10ps
`default_nettype none
module smch_frame_store (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [4:0] wr_idx,
    input wire logic [7:0] wr_data,
    output logic [smch_pkg::BUF_DEPTH*8-1:0] flat
);
    genvar g;
    generate
        for (g = 0; g < smch_pkg::BUF_DEPTH; g = g + 1) begin : g_entry
            logic [7:0] entry_reg;
            always_ff @(posedge mclk) begin
                if (srst) begin
                    entry_reg <= 8'h00;
                end else if (wr_en && wr_idx == 5'(g)) begin
                    entry_reg <= wr_data;
                end
            end
            assign flat[g*8 +: 8] = entry_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// file: logic/smch_cmd_handler.sv
// slave command handler for the serial parameter link of a servo drive
//
// Overview of operation
// R1: multi-write carries at most ten values
// R2: multi-write header: address, 0x10, index, count
// R3: byte-count field equals twice the count
// R4: each value high byte then low byte
// R5: values stored at consecutive indices from start
// R6: multi-write reply echoes header plus check code
// R7: check code sent low byte first
// R8: failure reply: code with bit 7, exception
// R9: diagnosis reply equals the request exactly
// R10: diagnosis data bytes echoed unchanged
// R11: save command copies parameters, short reply
// R12: master waits over five seconds after save
// R13: single write 0x1234 at 0x1001 saves
// R14: single write reply echoes the request
// R15: flag 0x55 enables servo, 0xAA disables
// R16: alarm clear clears alarms, echoes request
// R17: jog modes hold, forward, reverse, exit
// R18: jog speed taken from dedicated parameter
`timescale 1ns/10ps
`default_nettype none
module smch_cmd_handler (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] station_addr,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_frame_end,
    input wire logic save_busy,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    output logic busy,
    output logic par_wr_en,
    output logic [15:0] par_wr_index,
    output logic [15:0] par_wr_data,
    output logic save_start,
    output logic alarm_clear,
    output logic servo_enable,
    output logic [1:0] jog_mode,
    output logic [15:0] jog_speed_cmd
);
    smch_pkg::smch_state_e state_reg, state_next;
    logic [5:0] rx_cnt_reg, rx_cnt_next;
    logic overflow_reg, overflow_next;
    logic [7:0] exc_code_reg, exc_code_next;
    logic [3:0] wr_i_reg, wr_i_next;
    logic [5:0] tx_idx_reg, tx_idx_next;
    logic [5:0] tx_len_reg, tx_len_next;
    logic fresh_crc_reg, fresh_crc_next;
    logic [7:0] tx_data_reg, tx_data_next;
    logic tx_valid_reg, tx_valid_next;
    logic tx_last_reg, tx_last_next;
    logic par_wr_en_reg, par_wr_en_next;
    logic [15:0] par_wr_index_reg, par_wr_index_next;
    logic [15:0] par_wr_data_reg, par_wr_data_next;
    logic save_start_reg, alarm_clear_reg, busy_reg;
    logic servo_enable_reg, servo_enable_next;
    logic [1:0] jog_mode_reg, jog_mode_next;
    logic [15:0] jog_speed_param_reg, jog_speed_cmd_reg;

    logic [smch_pkg::BUF_DEPTH*8-1:0] store_flat;
    logic [7:0] fb [smch_pkg::BUF_DEPTH];
    logic [15:0] rx_crc, tx_crc;

    genvar g;
    generate
        for (g = 0; g < smch_pkg::BUF_DEPTH; g = g + 1) begin : g_byte
            assign fb[g] = store_flat[g*8 +: 8];
        end
    endgenerate

    // received frame fields
    wire [7:0] fc = fb[smch_pkg::POS_FC];
    wire [7:0] arg = fb[smch_pkg::POS_ARG];
    wire [15:0] idx16 = {fb[smch_pkg::POS_ARG], fb[smch_pkg::POS_IDX_L]};
    wire [15:0] cnt16 = {fb[smch_pkg::POS_CNT_H], fb[smch_pkg::POS_CNT_L]};
    wire [7:0] byte_cnt = fb[smch_pkg::POS_BYTES];

    wire is_diag = fc == smch_pkg::FC_DIAG;
    wire is_one = fc == smch_pkg::FC_WRITE_ONE;
    wire is_multi = fc == smch_pkg::FC_WRITE_MULTI;
    wire is_save = fc == smch_pkg::FC_SAVE;
    wire is_servo = fc == smch_pkg::FC_SERVO;
    wire is_alarm = fc == smch_pkg::FC_ALARM_CLR;
    wire is_jog = fc == smch_pkg::FC_JOG;
    wire known = is_diag | is_one | is_multi | is_save | is_servo | is_alarm | is_jog;

    // the check code is taken over the whole frame, so a good frame leaves the residue
    wire frame_ok = rx_cnt_reg >= smch_pkg::LEN_MIN && !overflow_reg
                    && fb[smch_pkg::POS_ADDR] == station_addr
                    && rx_crc == smch_pkg::CRC_RESIDUE; // R7

    wire count_ok = cnt16 != 16'h0000 && cnt16 <= smch_pkg::MAX_WRITE_COUNT; // R1
    wire bytes_ok = {8'h00, byte_cnt} == {cnt16[14:0], 1'b0}; // R3
    wire [6:0] multi_len = smch_pkg::LEN_MULTI_FIXED + {1'b0, cnt16[4:0], 1'b0}; // R2
    wire [16:0] multi_end = {1'b0, idx16} + {1'b0, cnt16};
    wire range_ok = multi_end <= smch_pkg::PARAM_COUNT;
    wire save_key_hit = is_one && idx16 == smch_pkg::SAVE_KEY_INDEX
                        && cnt16 == smch_pkg::SAVE_KEY_VALUE; // R13
    wire one_idx_ok = {1'b0, idx16} < smch_pkg::PARAM_COUNT
                      || idx16 == smch_pkg::SAVE_KEY_INDEX;

    wire len_ok = is_multi ? ({1'b0, rx_cnt_reg} == multi_len)
                : is_diag ? (rx_cnt_reg == smch_pkg::LEN_DIAG)
                : is_one ? (rx_cnt_reg == smch_pkg::LEN_WRITE_ONE)
                : (is_servo | is_jog) ? (rx_cnt_reg == smch_pkg::LEN_ONE_ARG)
                : (rx_cnt_reg == smch_pkg::LEN_BARE);

    wire servo_arg_ok = arg == smch_pkg::SERVO_ON || arg == smch_pkg::SERVO_OFF;
    wire jog_arg_ok = arg <= smch_pkg::JOG_HOLD;

    // priority: unknown code, malformed frame, bad index, bad argument, busy
    wire [7:0] exc_code = !known ? smch_pkg::EXC_BAD_FUNC
                        : (is_multi && !(count_ok && bytes_ok)) ? smch_pkg::EXC_BAD_VALUE
                        : !len_ok ? smch_pkg::EXC_BAD_VALUE
                        : (is_multi && !range_ok) ? smch_pkg::EXC_BAD_INDEX
                        : (is_one && !one_idx_ok) ? smch_pkg::EXC_BAD_INDEX
                        : (is_servo && !servo_arg_ok) ? smch_pkg::EXC_BAD_VALUE
                        : (is_jog && !jog_arg_ok) ? smch_pkg::EXC_BAD_VALUE
                        : ((is_save || save_key_hit) && save_busy) ? smch_pkg::EXC_BUSY
                        : smch_pkg::EXC_NONE; // R8

    wire in_check = state_reg == smch_pkg::ST_CHECK;
    wire accept = in_check && frame_ok && exc_code == smch_pkg::EXC_NONE;
    wire rx_take = state_reg == smch_pkg::ST_IDLE && rx_valid && !rx_frame_end;
    wire rx_store = rx_take && rx_cnt_reg != smch_pkg::BUF_FULL;
    wire can_load = !tx_valid_reg || tx_ready;
    wire tx_feed = state_reg == smch_pkg::ST_TX && can_load;

    // multi-write walk: value i sits at data position + 2i
    wire [4:0] hi_pos = smch_pkg::POS_DATA + {wr_i_reg, 1'b0}; // R4
    wire [4:0] lo_pos = hi_pos + 5'h01;
    wire [15:0] multi_index = idx16 + {12'h000, wr_i_reg}; // R5
    wire last_value = {12'h000, wr_i_reg} == cnt16 - 16'h0001;

    // store write port: incoming bytes, or the two exception fields over the request
    wire st_we = rx_store || state_reg == smch_pkg::ST_EXC_FC
                 || state_reg == smch_pkg::ST_EXC_CODE;
    wire [4:0] st_idx = state_reg == smch_pkg::ST_EXC_FC ? smch_pkg::POS_FC
                      : state_reg == smch_pkg::ST_EXC_CODE ? smch_pkg::POS_ARG
                      : rx_cnt_reg[4:0];
    wire [7:0] st_data = state_reg == smch_pkg::ST_EXC_FC ? (fc | smch_pkg::FC_EXC_FLAG)
                       : state_reg == smch_pkg::ST_EXC_CODE ? exc_code_reg
                       : rx_data; // R8

    wire jog_speed_hit = par_wr_en_next && par_wr_index_next == smch_pkg::JOG_SPEED_INDEX;
    wire [15:0] jog_speed_cmd_next = jog_mode_next == smch_pkg::JOG_FWD[1:0]
                                     ? jog_speed_param_reg
                                   : jog_mode_next == smch_pkg::JOG_REV[1:0]
                                     ? 16'h0000 - jog_speed_param_reg
                                   : 16'h0000; // R18

    smch_frame_store u_store (
        .mclk(mclk),
        .srst(srst),
        .wr_en(st_we),
        .wr_idx(st_idx),
        .wr_data(st_data),
        .flat(store_flat)
    );

    smch_crc16 u_rx_crc (
        .mclk(mclk),
        .srst(srst),
        .clear(in_check),
        .byte_valid(rx_store),
        .byte_data(rx_data),
        .crc(rx_crc)
    );

    smch_crc16 u_tx_crc (
        .mclk(mclk),
        .srst(srst),
        .clear(in_check),
        .byte_valid(tx_feed),
        .byte_data(fb[tx_idx_reg[4:0]]),
        .crc(tx_crc)
    );

    always_comb begin
        state_next = state_reg;
        rx_cnt_next = rx_cnt_reg;
        overflow_next = overflow_reg;
        exc_code_next = exc_code_reg;
        wr_i_next = wr_i_reg;
        tx_idx_next = tx_idx_reg;
        tx_len_next = tx_len_reg;
        fresh_crc_next = fresh_crc_reg;
        tx_data_next = tx_data_reg;
        tx_valid_next = tx_valid_reg && !tx_ready;
        tx_last_next = tx_last_reg && !tx_ready;
        par_wr_en_next = 1'b0;
        par_wr_index_next = par_wr_index_reg;
        par_wr_data_next = par_wr_data_reg;
        servo_enable_next = servo_enable_reg;
        jog_mode_next = jog_mode_reg;
        case (state_reg)
            smch_pkg::ST_IDLE: begin
                if (rx_frame_end) begin
                    state_next = smch_pkg::ST_CHECK;
                end else if (rx_take) begin
                    if (rx_store) begin
                        rx_cnt_next = rx_cnt_reg + 6'h01;
                    end else begin
                        overflow_next = 1'b1;
                    end
                end
            end
            smch_pkg::ST_CHECK: begin
                exc_code_next = exc_code;
                wr_i_next = 4'h0;
                tx_idx_next = 6'h00;
                rx_cnt_next = 6'h00;
                overflow_next = 1'b0;
                // silent drop for foreign address or damaged frame
                if (!frame_ok) begin
                    state_next = smch_pkg::ST_IDLE;
                end else if (exc_code != smch_pkg::EXC_NONE) begin
                    state_next = smch_pkg::ST_EXC_FC;
                end else if (is_multi) begin
                    state_next = smch_pkg::ST_WRITE;
                end else begin
                    // echo replies resend the stored request with its own check code
                    tx_len_next = rx_cnt_reg; // R9 R10 R11 R14 R16
                    fresh_crc_next = 1'b0;
                    state_next = smch_pkg::ST_TX;
                end
                if (accept && is_one && {1'b0, idx16} < smch_pkg::PARAM_COUNT) begin
                    par_wr_en_next = 1'b1;
                    par_wr_index_next = idx16;
                    par_wr_data_next = cnt16;
                end
                if (accept && is_servo) begin
                    servo_enable_next = arg == smch_pkg::SERVO_ON; // R15
                    jog_mode_next = smch_pkg::JOG_EXIT[1:0];
                end
                if (accept && is_jog) begin
                    servo_enable_next = arg != smch_pkg::JOG_EXIT; // R17
                    jog_mode_next = arg[1:0];
                end
            end
            smch_pkg::ST_WRITE: begin
                par_wr_en_next = 1'b1;
                par_wr_index_next = multi_index; // R5
                par_wr_data_next = {fb[hi_pos], fb[lo_pos]}; // R4
                wr_i_next = wr_i_reg + 4'h1;
                if (last_value) begin
                    tx_len_next = smch_pkg::LEN_MULTI_REPLY; // R6
                    fresh_crc_next = 1'b1;
                    state_next = smch_pkg::ST_TX;
                end
            end
            smch_pkg::ST_EXC_FC: begin
                state_next = smch_pkg::ST_EXC_CODE;
            end
            smch_pkg::ST_EXC_CODE: begin
                tx_len_next = smch_pkg::LEN_EXC_REPLY; // R8
                fresh_crc_next = 1'b1;
                state_next = smch_pkg::ST_TX;
            end
            smch_pkg::ST_TX: begin
                if (can_load) begin
                    tx_data_next = fb[tx_idx_reg[4:0]];
                    tx_valid_next = 1'b1;
                    tx_idx_next = tx_idx_reg + 6'h01;
                    if (tx_idx_reg == tx_len_reg - 6'h01) begin
                        tx_last_next = !fresh_crc_reg;
                        state_next = fresh_crc_reg ? smch_pkg::ST_TX_CRC_LO
                                                   : smch_pkg::ST_DRAIN;
                    end
                end
            end
            smch_pkg::ST_TX_CRC_LO: begin
                if (can_load) begin
                    tx_data_next = tx_crc[7:0]; // R7
                    tx_valid_next = 1'b1;
                    state_next = smch_pkg::ST_TX_CRC_HI;
                end
            end
            smch_pkg::ST_TX_CRC_HI: begin
                if (can_load) begin
                    tx_data_next = tx_crc[15:8]; // R7
                    tx_valid_next = 1'b1;
                    tx_last_next = 1'b1;
                    state_next = smch_pkg::ST_DRAIN;
                end
            end
            smch_pkg::ST_DRAIN: begin
                if (tx_ready) begin
                    state_next = smch_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = smch_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= smch_pkg::ST_IDLE;
            rx_cnt_reg <= 6'h00;
            overflow_reg <= 1'b0;
            exc_code_reg <= smch_pkg::EXC_NONE;
            wr_i_reg <= 4'h0;
            tx_idx_reg <= 6'h00;
            tx_len_reg <= 6'h00;
            fresh_crc_reg <= 1'b0;
            tx_data_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            tx_last_reg <= 1'b0;
            busy_reg <= 1'b0;
            par_wr_en_reg <= 1'b0;
            par_wr_index_reg <= 16'h0000;
            par_wr_data_reg <= 16'h0000;
            save_start_reg <= 1'b0;
            alarm_clear_reg <= 1'b0;
            servo_enable_reg <= 1'b0;
            jog_mode_reg <= 2'b00;
            jog_speed_param_reg <= smch_pkg::JOG_SPEED_RESET;
            jog_speed_cmd_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            rx_cnt_reg <= rx_cnt_next;
            overflow_reg <= overflow_next;
            exc_code_reg <= exc_code_next;
            wr_i_reg <= wr_i_next;
            tx_idx_reg <= tx_idx_next;
            tx_len_reg <= tx_len_next;
            fresh_crc_reg <= fresh_crc_next;
            tx_data_reg <= tx_data_next;
            tx_valid_reg <= tx_valid_next;
            tx_last_reg <= tx_last_next;
            busy_reg <= state_next != smch_pkg::ST_IDLE;
            par_wr_en_reg <= par_wr_en_next;
            par_wr_index_reg <= par_wr_index_next;
            par_wr_data_reg <= par_wr_data_next;
            save_start_reg <= accept && (is_save || save_key_hit); // R11 R13
            alarm_clear_reg <= accept && is_alarm; // R16
            servo_enable_reg <= servo_enable_next;
            jog_mode_reg <= jog_mode_next;
            if (jog_speed_hit) begin
                jog_speed_param_reg <= par_wr_data_next; // R18
            end
            jog_speed_cmd_reg <= jog_speed_cmd_next;
        end
    end

    assign tx_data = tx_data_reg;
    assign tx_valid = tx_valid_reg;
    assign tx_last = tx_last_reg;
    assign busy = busy_reg;
    assign par_wr_en = par_wr_en_reg;
    assign par_wr_index = par_wr_index_reg;
    assign par_wr_data = par_wr_data_reg;
    assign save_start = save_start_reg;
    assign alarm_clear = alarm_clear_reg;
    assign servo_enable = servo_enable_reg;
    assign jog_mode = jog_mode_reg;
    assign jog_speed_cmd = jog_speed_cmd_reg;
endmodule
`default_nettype wire

// file: tb/smch_cmd_handler_chk.sv
// port assertions for the serial command handler
`timescale 1ns/10ps
`default_nettype none
module smch_cmd_handler_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] station_addr,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_frame_end,
    input wire logic save_busy,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic busy,
    input wire logic par_wr_en,
    input wire logic [15:0] par_wr_index,
    input wire logic [15:0] par_wr_data,
    input wire logic save_start,
    input wire logic alarm_clear,
    input wire logic servo_enable,
    input wire logic [1:0] jog_mode,
    input wire logic [15:0] jog_speed_cmd
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    AST_BUSY_RISE: assert property (rx_frame_end && !busy |=> busy)
        else $error("busy did not follow frame end");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed before acceptance");
    AST_LAST_VALID: assert property (tx_last |-> tx_valid)
        else $error("last flag without valid byte");
    AST_LAST_END: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid ##[0:1] !busy)
        else $error("reply did not end after last byte");
    AST_WR_SEQ: assert property (par_wr_en ##1 par_wr_en |-> par_wr_index == $past(par_wr_index) + 16'h0001)
        else $error("write indices not consecutive");
    AST_SAVE_PULSE: assert property (save_start |=> !save_start)
        else $error("save start longer than one cycle");
    AST_CLR_PULSE: assert property (alarm_clear |=> !alarm_clear)
        else $error("alarm clear longer than one cycle");
    AST_JOG_EN: assert property (jog_mode != 2'h0 |-> servo_enable)
        else $error("jog active without enable");
    AST_JOG_ZERO: assert property (jog_mode[0] == jog_mode[1] ##1 $stable(jog_mode) |-> jog_speed_cmd == 16'h0000)
        else $error("jog speed not zero outside rotation");
    cover property (tx_valid && tx_ready && tx_last);
    cover property (par_wr_en ##1 par_wr_en);
    cover property (save_start);
endmodule
bind smch_cmd_handler smch_cmd_handler_chk i_chk (.*);
`default_nettype wire

// file: tb/smch_host_model.sv
// behavioural master host: sends request frames, sinks replies
`timescale 1ns/10ps
`default_nettype none
module smch_host_model (
    input wire logic mclk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_frame_end,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic done = 1'b0;
    logic [7:0] rsp[$];
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_frame_end = 1'b0;
        tx_ready = 1'b1;
    end
    // a slow host takes a byte only every other cycle
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) begin
            rsp.push_back(tx_data);
            if (tx_last) begin
                done <= 1'b1;
            end
        end
        tx_ready <= #1 slow ? ~tx_ready : 1'b1;
    end
    task automatic send(input logic [7:0] f[$]);
        done = 1'b0;
        rsp.delete();
        foreach (f[i]) begin
            @(posedge mclk);
            #1;
            rx_valid = 1'b1;
            rx_data = f[i];
        end
        @(posedge mclk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        rx_frame_end = 1'b1;
        @(posedge mclk);
        #1;
        rx_frame_end = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/smch_cmd_handler_tb.sv
// self-checking bench for the serial command handler
`timescale 1ns/10ps
`default_nettype none
module smch_cmd_handler_tb;
    typedef logic [7:0] smch_bytes_t[$];
    localparam logic [7:0] A = 8'h11;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic save_busy = 1'b0;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, rx_frame_end, tx_ready, tx_valid, tx_last, busy, par_wr_en, save_start;
    logic alarm_clear, servo_enable;
    logic [1:0] jog_mode;
    logic [15:0] par_wr_index, par_wr_data, jog_speed_cmd;
    logic [15:0] wr_log[$];
    logic [7:0] jm[4] = '{8'h03, 8'h01, 8'h02, 8'h00};
    int n_errors = 0;
    int tests_run = 0;
    int saves = 0, clears = 0;
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (par_wr_en) begin
            wr_log.push_back(par_wr_index);
            wr_log.push_back(par_wr_data);
        end
        saves += save_start;
        clears += alarm_clear;
    end
    smch_cmd_handler i_smch_cmd_handler (.station_addr(A), .*);
    smch_host_model i_smch_host_model (.*);
    function automatic smch_bytes_t add_crc(smch_bytes_t f);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
            end
        end
        return {f, c[7:0], c[15:8]};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(smch_bytes_t req, smch_bytes_t exp);
        smch_bytes_t e;
        int k;
        e = add_crc(exp);
        i_smch_host_model.send(add_crc(req));
        for (k = 0; k < 400 && i_smch_host_model.done !== 1'b1; k++) begin
            @(posedge mclk);
        end
        if (k == 400) begin
            n_errors++;
            test_done();
        end
        repeat (3) @(posedge mclk);
        #1;
        check("reply length", 16'(e.size()), 16'(i_smch_host_model.rsp.size()));
        foreach (e[i]) check("reply byte", {8'h00, e[i]}, {8'h00, i_smch_host_model.rsp[i]});
    endtask
    task automatic echo(smch_bytes_t req);
        xfer(req, req);
    endtask
    task automatic s_multi();
        smch_bytes_t r;
        r = {A, 8'h10, 8'h00, 8'hF6, 8'h00, 8'h0A, 8'h14};
        for (int i = 0; i < 10; i++) r = {r, 8'(i), 8'(8'h50 + i)};
        xfer(r, {A, 8'h10, 8'h00, 8'hF6, 8'h00, 8'h0A});
        check("write count", 16'(wr_log.size()), 16'h0014);
        for (int i = 0; i < 10; i++) check("write index", wr_log[2*i], 16'h00F6 + 16'(i));
        for (int i = 0; i < 10; i++) check("write data", wr_log[2*i+1], {8'(i), 8'(8'h50 + i)});
        r = {A, 8'h10, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h16};
        for (int i = 0; i < 22; i++) r = {r, 8'h00};
        xfer(r, {A, 8'h90, 8'h03});
        xfer({A, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h12, 8'h34}, {A, 8'h90, 8'h03});
        check("refused writes", 16'(wr_log.size()), 16'h0014);
    endtask
    task automatic s_misc();
        i_smch_host_model.slow = 1'b1;
        echo({A, 8'h08, 8'hAB, 8'hCD});
        i_smch_host_model.slow = 1'b0;
        echo({A, 8'h41});
        check("save pulses", 16'(saves), 16'h0001);
        save_busy = 1'b1;
        xfer({A, 8'h41}, {A, 8'hC1, 8'h04});
        save_busy = 1'b0;
        echo({A, 8'h06, 8'h10, 8'h01, 8'h12, 8'h34});
        check("save pulses", 16'(saves), 16'h0002);
        xfer({A, 8'h06, 8'h02, 8'h00, 8'h00, 8'h01}, {A, 8'h86, 8'h02});
        xfer({A, 8'h05}, {A, 8'h85, 8'h01});
        echo({A, 8'h43});
        check("alarm clears", 16'(clears), 16'h0001);
        echo({A, 8'h42, 8'h55});
        check("servo enable", 16'(servo_enable), 16'h0001);
        echo({A, 8'h42, 8'hAA});
        check("servo enable", 16'(servo_enable), 16'h0000);
        xfer({A, 8'h42, 8'h33}, {A, 8'hC2, 8'h03});
    endtask
    task automatic s_jog();
        echo({A, 8'h06, 8'h00, 8'h4C, 8'h01, 8'h2C});
        for (int i = 0; i < 4; i++) begin
            echo({A, 8'h44, jm[i]});
            check("jog mode", 16'(jm[i][1:0]), 16'(jog_mode));
            check("servo enable", 16'(jm[i] != 8'h00), 16'(servo_enable));
            check("jog speed", jm[i] == 8'h01 ? 16'h012C : jm[i] == 8'h02 ? 16'hFED4 : 16'h0000,
                jog_speed_cmd);
        end
        xfer({A, 8'h44, 8'h04}, {A, 8'hC4, 8'h03});
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        srst = 1'b0;
        s_multi();
        s_misc();
        s_jog();
        test_done();
    end
endmodule
`default_nettype wire
